// ---- design/tcr_fifo.sv ----
// Purpose: small flip-flop fifo for conversion samples
// Assumes: single clock, asynchronous active-high reset
// Notes: in_ready_out and out_valid_out are registered
module tcr_fifo
    import tcr_pkg::*;
#(
    parameter int WIDTH = SAMPLE_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // fill side
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    // drain side
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        push = in_valid_in && (cnt_q != FULL);
        pop = out_ready_in && (cnt_q != '0);
        wr_d = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready_out <= 1'b0;
            out_valid_out <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            in_ready_out <= (cnt_d != FULL);
            out_valid_out <= (cnt_d != '0);
        end
    end

    // storage has no reset; empty flag guards it
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_slot
            always_ff @(posedge clock_in) begin
                if (push && wr_q == AW'(gi)) begin
                    mem_q[gi] <= in_data_in;
                end
            end
        end
    endgenerate

    assign out_data_out = mem_q[rd_q];
endmodule : tcr_fifo

// ---- design/tcr_pkg.sv ----
// Purpose: shared constants for the thermocouple serial readout
// Assumes: 250 MHz system clock
// Notes: frame layout, conversion timing, sample buffer shape
package tcr_pkg;
    // ---------------------------------------------------------------
    // frame layout
    // ---------------------------------------------------------------
    localparam int FRAME_W = 32;
    localparam int TC_W = 14;
    localparam int CJ_W = 12;
    localparam int TC_MSB = 31;
    localparam int TC_LSB = 18;
    localparam int CJ_MSB = 15;
    localparam int CJ_LSB = 4;
    localparam int RES_BIT = 3;
    localparam int SUPPLY_BIT = 2;
    localparam int GROUND_BIT = 1;
    localparam int OPEN_BIT = 0;
    localparam int SAMPLE_W = TC_W + CJ_W + 3;
    localparam logic [FRAME_W-1:0] FRAME_RST = 32'h0000_0000;
    // ---------------------------------------------------------------
    // timing and buffering
    // ---------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int CONV_TIME_MS = 100;
    localparam int CONV_CYCLES = CONV_TIME_MS * 1000 * CLK_MHZ;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        TCR_IDLE  = 2'b01,
        TCR_SHIFT = 2'b10
    } tcr_state_e;

    // sample word {tc, cj, supply, ground, open} into the serial frame
    function automatic logic [FRAME_W-1:0] tcr_pack(input logic [SAMPLE_W-1:0] s);
        logic [FRAME_W-1:0] f;
        f = FRAME_RST;
        f[TC_MSB:TC_LSB] = s[SAMPLE_W-1 -: TC_W];
        f[CJ_MSB:CJ_LSB] = s[SAMPLE_W-1-TC_W -: CJ_W];
        f[RES_BIT] = 1'b0;
        f[SUPPLY_BIT] = s[2];
        f[GROUND_BIT] = s[1];
        f[OPEN_BIT] = s[0];
        return f;
    endfunction : tcr_pack
endpackage : tcr_pkg

// ---- design/tcr_readout.sv ----
// Purpose: device-side serial readout of thermocouple conversion results
// Assumes: select and serial clock are pins, sampled by clock_in
// Notes: serial clock must stay well below a quarter of clock_in
// What this block does
// - the sign bit appears on the data line when select falls, for the host's next rising edge.
// - each next bit, most significant first, is shifted out on every falling serial clock edge.
// - results are refreshed only while select is high.
// - bits 31 to 18 carry the thermocouple temperature, sign first, 0.25 degree steps.
// - bits 15 to 4 carry the internal temperature, sign first, 0.0625 degree steps.
// - both temperatures are two's complement and pass unchanged into the frame.
// - bit 2 flags short to supply, bit 1 short to ground, bit 0 open circuit; bit 3 reads zero.
// - a new conversion result is accepted at most once per 100 ms.
module tcr_readout
    import tcr_pkg::*;
#(
    parameter int CONV_CNT = CONV_CYCLES
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // serial link pins
    input wire logic sel_n_in,
    input wire logic sclk_in,
    output logic miso_out,
    output logic miso_oe_out,
    // conversion samples
    input wire logic sample_valid_in,
    input wire logic [TC_W-1:0] sample_tc_in,
    input wire logic [CJ_W-1:0] sample_cj_in,
    input wire logic short_to_supply_flag_in,
    input wire logic short_to_ground_flag_in,
    input wire logic open_circuit_flag_in,
    output logic sample_ready_out,
    // status
    output logic result_valid_out
);
    localparam int TW = $clog2(CONV_CNT + 1);

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic sel_s1_q, sel_s2_q, sel_s3_q;
    logic sck_s1_q, sck_s2_q, sck_s3_q;
    logic sel_fall, sel_rise, sck_fall;

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sel_s1_q <= 1'b1;
            sel_s2_q <= 1'b1;
            sel_s3_q <= 1'b1;
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
        end else begin
            sel_s1_q <= sel_n_in;
            sel_s2_q <= sel_s1_q;
            sel_s3_q <= sel_s2_q;
            sck_s1_q <= sclk_in;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
        end
    end

    assign sel_fall = !sel_s2_q && sel_s3_q;
    assign sel_rise = sel_s2_q && !sel_s3_q;
    assign sck_fall = !sck_s2_q && sck_s3_q;

    // ---------------------------------------------------------------
    // sample buffer and conversion pacing
    // ---------------------------------------------------------------
    logic fifo_valid, take;
    logic [SAMPLE_W-1:0] fifo_data;
    logic [SAMPLE_W-1:0] result_q, result_d;
    logic [TW-1:0] conv_q, conv_d;
    logic have_q, have_d;

    tcr_fifo #(
        .WIDTH(SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .in_valid_in(sample_valid_in),
        .in_data_in({sample_tc_in, sample_cj_in, short_to_supply_flag_in,
                     short_to_ground_flag_in, open_circuit_flag_in}),
        .in_ready_out(sample_ready_out),
        .out_valid_out(fifo_valid),
        .out_data_out(fifo_data),
        .out_ready_in(take)
    );

    // a slow drain is the back-pressure: samples wait until pacing allows
    always_comb begin
        take = fifo_valid && sel_s2_q && sel_s3_q && (conv_q == '0);
        result_d = take ? fifo_data : result_q;
        have_d = have_q || take;
        conv_d = take ? TW'(CONV_CNT - 1) : ((conv_q != '0) ? conv_q - 1'b1 : conv_q);
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            result_q <= '0;
            have_q <= 1'b0;
            conv_q <= '0;
            result_valid_out <= 1'b0;
        end else begin
            result_q <= result_d;
            have_q <= have_d;
            conv_q <= conv_d;
            result_valid_out <= have_d;
        end
    end

    // ---------------------------------------------------------------
    // frame shifter
    // ---------------------------------------------------------------
    tcr_state_e state_q, state_d;
    logic [FRAME_W-1:0] shift_q, shift_d;
    logic oe_d;

    always_comb begin
        state_d = state_q;
        shift_d = shift_q;
        oe_d = miso_oe_out;
        unique case (state_q)
            TCR_IDLE: begin
                if (sel_fall) begin
                    shift_d = tcr_pack(result_q);
                    oe_d = 1'b1;
                    state_d = TCR_SHIFT;
                end
            end
            TCR_SHIFT: begin
                if (sel_s2_q) begin
                    oe_d = 1'b0;
                    state_d = TCR_IDLE;
                end else if (sck_fall) begin
                    shift_d = {shift_q[FRAME_W-2:0], 1'b0};
                end
            end
            default: begin
                state_d = TCR_IDLE;
                oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= TCR_IDLE;
            shift_q <= FRAME_RST;
            miso_oe_out <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            miso_oe_out <= oe_d;
        end
    end

    // msb of the shifter is the line; bits past 32 read zero
    assign miso_out = shift_q[FRAME_W-1];

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    first_bit_a: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (state_q == TCR_IDLE && sel_fall) |=>
            miso_oe_out && miso_out == $past(result_q[SAMPLE_W-1]))
        else $error("sign bit not presented at select fall");

    msb_shift_a: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (state_q == TCR_SHIFT && !sel_s2_q && sck_fall) |=>
            shift_q == {$past(shift_q[FRAME_W-2:0]), 1'b0})
        else $error("frame did not shift on falling serial clock");

    line_release_a: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (state_q == TCR_SHIFT && sel_s2_q) |=> !miso_oe_out ##1 !miso_oe_out || sel_fall)
        else $error("data line still driven after select high");

    refresh_hold_a: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (!sel_s2_q && !sel_s3_q) |=> $stable(result_q))
        else $error("result changed while selected");

    tc_field_a: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (state_q == TCR_IDLE && sel_fall) |=>
            shift_q[TC_MSB:TC_LSB] == $past(result_q[SAMPLE_W-1 -: TC_W]))
        else $error("thermocouple field wrong in frame");

    cj_field_a: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (state_q == TCR_IDLE && sel_fall) |=>
            shift_q[CJ_MSB:CJ_LSB] == $past(result_q[SAMPLE_W-1-TC_W -: CJ_W]))
        else $error("internal temperature field wrong in frame");

    fault_bits_a: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (state_q == TCR_IDLE && sel_fall) |=>
            shift_q[RES_BIT:OPEN_BIT] == {1'b0, $past(result_q[2:0])})
        else $error("fault bits wrong in frame");

    conv_pace_a: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        take |=> conv_q == TW'(CONV_CNT - 1) && !take)
        else $error("conversion pacing not restarted");

    frame_hold_a: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (state_q == TCR_SHIFT && !sel_s2_q && !sck_fall) |=> $stable(shift_q))
        else $error("frame changed during read without clock edge");

    // line only driven between a select fall and the matching rise
    oe_idle_a: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (state_q == TCR_IDLE && !sel_fall) |=> !miso_oe_out)
        else $error("data line driven outside a read");

    pace_block_a: assert property (
        @(posedge clock_in) disable iff (sys_rst_in)
        (conv_q != '0) |-> !take)
        else $error("sample taken before pacing ran out");
endmodule : tcr_readout

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for the thermocouple readout
// Assumes: short pacing count in simulation
// Notes: expected frames built from the sample words
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tcr_pkg::*;
    localparam int CONV = 20;
    localparam int PWRUP = 5;
    logic clock_in = 1'b0;
    logic sys_rst_in, sel_n, sclk, miso, miso_oe, s_valid, s_ready, r_valid;
    logic [TC_W-1:0] s_tc;
    logic [CJ_W-1:0] s_cj;
    logic f_sup, f_gnd, f_open, ok;
    logic [31:0] lfsr_q, fr;
    logic [28:0] s, prev;
    logic [28:0] smp_q[$];
    int error_cnt, num_checks, cnt;
    logic [28:0] corner[3] = '{29'h032_0c84, 29'h1fff_fffa, 29'h1f41_9211};
    initial begin
        forever #2 clock_in = ~clock_in;
    end
    tcr_readout #(.CONV_CNT(CONV)) tcr_readout_inst (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .sel_n_in(sel_n),
        .sclk_in(sclk), .miso_out(miso), .miso_oe_out(miso_oe),
        .sample_valid_in(s_valid), .sample_tc_in(s_tc), .sample_cj_in(s_cj),
        .short_to_supply_flag_in(f_sup), .short_to_ground_flag_in(f_gnd),
        .open_circuit_flag_in(f_open), .sample_ready_out(s_ready),
        .result_valid_out(r_valid));
    tcr_host tcr_host_inst (.clock_in(clock_in), .sel_n_out(sel_n),
        .sclk_out(sclk), .miso_in(miso), .miso_oe_in(miso_oe));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next
    function automatic logic [31:0] exp_frame(input logic [28:0] w);
        return {w[28:15], 2'b00, w[14:3], 1'b0, w[2:0]};
    endfunction : exp_frame
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check32
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : wait_clk
    // bounded wait on ready; a refusal just leaves ok low
    task automatic push(input logic [28:0] w, output logic acc);
        acc = 1'b0;
        wait_clk(1);
        {s_tc, s_cj, f_sup, f_gnd, f_open} = w;
        s_valid = 1'b1;
        for (int i = 0; i < 4 && !acc; i++) begin
            @(posedge clock_in);
            acc = (s_ready === 1'b1);
            #1;
        end
        s_valid = 1'b0;
    endtask : push
    task automatic read(input int n);
        tcr_host_inst.sel_low();
        tcr_host_inst.clock_bits(n, fr);
        tcr_host_inst.sel_high();
    endtask : read
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        error_cnt = 0;
        num_checks = 0;
        lfsr_q = 32'h0001_653b;
        sys_rst_in = 1'b1;
        s_valid = 1'b0;
        {s_tc, s_cj, f_sup, f_gnd, f_open} = 29'h0;
        repeat (10) @(posedge clock_in);
        #1 sys_rst_in = 1'b0;
        wait_clk(PWRUP);
        check32({30'h0, miso_oe, r_valid}, 32'h0);
        read(32);
        check32(fr, 32'h0);
        for (int i = 0; i < 8; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            s = (i < 3) ? corner[i] : lfsr_q[28:0];
            push(s, ok);
            check32({31'h0, ok}, 32'h1);
            wait_clk(CONV + 10);
            check32({31'h0, r_valid}, 32'h1);
            read((i % 2) ? 14 : 32);
            if (i % 2) begin
                check32({18'h0, fr[13:0]}, exp_frame(s) >> TC_LSB);
            end else begin
                check32(fr, exp_frame(s));
            end
            wait_clk(6);
            check32({31'h0, miso_oe}, 32'h0);
            prev = s;
        end
        tcr_host_inst.sel_low();
        cnt = 0;
        for (int k = 0; k < 10; k++) begin
            lfsr_q = lfsr_next(lfsr_q);
            push(lfsr_q[28:0], ok);
            if (ok) begin
                smp_q.push_back(lfsr_q[28:0]);
                cnt++;
            end
        end
        check32(cnt, FIFO_DEPTH);
        tcr_host_inst.clock_bits(32, fr);
        check32(fr, exp_frame(prev));
        tcr_host_inst.sel_high();
        for (int k = 0; k < FIFO_DEPTH; k++) begin
            wait_clk(12);
            read(32);
            check32(fr, exp_frame(smp_q.pop_front()));
        end
        tally_and_finish();
    end
endmodule : tb_top

// ---- testbench/tcr_host.sv ----
// Purpose: serial master model reading frames
// Assumes: half period of four system clocks
// Notes: serial clock stands low outside frames
module tcr_host (
    // system clock
    input wire logic clock_in,
    // serial link
    output logic sel_n_out,
    output logic sclk_out,
    input wire logic miso_in,
    input wire logic miso_oe_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sel_n_out = 1'b1;
        sclk_out = 1'b0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : step
    task automatic sel_low;
        step(1);
        sel_n_out = 1'b0;
        step(6);
    endtask : sel_low
    // released line reads the inverse, so a late driver cannot pass
    task automatic clock_bits(input int n, output logic [31:0] f);
        f = 32'h0000_0000;
        for (int i = 0; i < n; i++) begin
            sclk_out = 1'b1;
            f = {f[30:0], miso_oe_in ? miso_in : ~miso_in};
            step(4);
            sclk_out = 1'b0;
            step(4);
        end
    endtask : clock_bits
    task automatic sel_high;
        step(1);
        sel_n_out = 1'b1;
    endtask : sel_high
endmodule : tcr_host
